// >>> inc/fsf_pkg.sv
// Shared constants and types for the two-wire slave front end.
// Assumes one bus master on the far side that owns the serial clock.
package fsf_pkg;

   // ************************************************
   // Framing
   // ************************************************
   localparam int BYTE_W = 8;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_FIRST = 4'h1;
   localparam logic [3:0] BIT_NONE = 4'h0;
   localparam logic RW_READ = 1'b1;

   // ************************************************
   // Byte index within a write frame
   // ************************************************
   localparam logic [1:0] IDX_ADDR_HI = 2'h0;
   localparam logic [1:0] IDX_DATA = 2'h2;

   // ************************************************
   // Array behind the interface
   // ************************************************
   localparam int ADDR_W = 16;
   localparam int MEM_WORDS = 65536;

   // ************************************************
   // Reset values
   // ************************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_SEL = 3'h0;

   typedef enum logic [1:0] {
      FSF_IDLE = 2'h0,
      FSF_ADDR = 2'h1,
      FSF_WRX = 2'h3,
      FSF_RDX = 2'h2
   } fsf_state_t;

   typedef struct packed {
      logic [1:0] idx;
      logic [7:0] data;
   } fsf_rx_t;

endpackage

// >>> src/fsf_frontend.sv
// Two-wire serial slave front end: start/stop, bit shifting, acknowledge,
// address match and write-protect gating, with a user side on clk.
// Assumes the serial clock is the link clock and may stop between frames.
module fsf_frontend #(
   parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary device type code
) (
   // System clock and reset
   input wire logic clk,
   input wire logic reset,
   // Serial link
   input wire logic scl_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Straps
   input wire logic addr_sel_bit0,
   input wire logic addr_sel_bit1,
   input wire logic addr_sel_bit2,
   input wire logic wp_i,
   // Received bytes
   output logic rx_valid,
   output fsf_pkg::fsf_rx_t rx_word,
   output logic mem_wr,
   // Read data
   input wire logic [7:0] rd_byte,
   output logic rd_take,
   // Status
   output logic link_busy
);

   // ************************************************
   // Declarations
   // ************************************************
   fsf_pkg::fsf_state_t state_q;
   logic [3:0] bit_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q, tx_hold_q;
   logic [1:0] idx_q;
   fsf_pkg::fsf_rx_t link_rx_q;
   logic rx_tog_q, take_tog_q;
   logic start_tog_q, stop_tog_q, start_seen_q, stop_seen_q;
   logic [2:0] sel_s1_q, sel_s2_q;
   logic drive_q;
   logic wp_s1_q, wp_s2_q, busy_s1_q, busy_s2_q;
   logic [2:0] rx_s_q, take_s_q;
   logic load_q, rx_valid_q, mem_wr_q, rd_take_q;
   fsf_pkg::fsf_rx_t rx_word_q;
   logic start_pend, stop_pend, run, slot, match_w, rx_edge, take_edge;
   logic [2:0] tx_idx;

   if ((1 << fsf_pkg::ADDR_W) != fsf_pkg::MEM_WORDS) begin : g_chk
      $error("Array depth does not match address width");
   end

   // ************************************************
   // Start and stop detection
   // ************************************************
   // Data edges serve as clocks: the system clock is too slow to see them.
   always_ff @(negedge sda_i or posedge reset) begin
      if (reset) begin
         start_tog_q <= 1'b0;
      end else if (scl_clk) begin
         start_tog_q <= ~start_tog_q;
      end
   end

   always_ff @(posedge sda_i or posedge reset) begin
      if (reset) begin
         stop_tog_q <= 1'b0;
      end else if (scl_clk) begin
         stop_tog_q <= ~stop_tog_q;
      end
   end

   assign start_pend = start_tog_q ^ start_seen_q;
   assign stop_pend = stop_tog_q ^ stop_seen_q;
   assign run = !start_pend && !stop_pend && (state_q != fsf_pkg::FSF_IDLE);
   assign slot = (bit_q == fsf_pkg::ACK_SLOT);
   // Type code, then pins MSB first, then direction
   assign match_w = (shift_q[7:4] == DEV_TYPE) && (shift_q[3:1] == sel_s2_q);
   assign tx_idx = 3'(fsf_pkg::BIT_LAST - bit_q);

   // ************************************************
   // Link side, rising edge: sampling and sequencing
   // ************************************************
   // Open pins arrive low through the pad pull-downs
   always_ff @(posedge scl_clk or posedge reset) begin
      if (reset) begin
         sel_s1_q <= fsf_pkg::RST_SEL;
         sel_s2_q <= fsf_pkg::RST_SEL;
      end else begin
         sel_s1_q <= {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
         sel_s2_q <= sel_s1_q;
      end
   end

   always_ff @(posedge scl_clk or posedge reset) begin
      if (reset) begin
         start_seen_q <= 1'b0;
         stop_seen_q <= 1'b0;
         state_q <= fsf_pkg::FSF_IDLE;
         bit_q <= fsf_pkg::BIT_NONE;
      end else begin
         start_seen_q <= start_tog_q;
         stop_seen_q <= stop_tog_q;
         if (start_pend) begin
            state_q <= fsf_pkg::FSF_ADDR;
            bit_q <= fsf_pkg::BIT_FIRST;
         end else if (stop_pend) begin
            // No programming wait: next start is taken at once
            state_q <= fsf_pkg::FSF_IDLE;
            bit_q <= fsf_pkg::BIT_NONE;
         end else if (run && !slot) begin
            bit_q <= bit_q + 4'h1;
         end else if (run) begin
            bit_q <= fsf_pkg::BIT_NONE;
            unique case (state_q)
               fsf_pkg::FSF_ADDR: begin
                  if (!match_w) begin
                     state_q <= fsf_pkg::FSF_IDLE;
                  end else if (shift_q[0] == fsf_pkg::RW_READ) begin
                     state_q <= fsf_pkg::FSF_RDX;
                  end else begin
                     state_q <= fsf_pkg::FSF_WRX;
                  end
               end
               fsf_pkg::FSF_RDX: begin
                  if (sda_i) begin
                     state_q <= fsf_pkg::FSF_IDLE;
                  end
               end
               fsf_pkg::FSF_WRX, fsf_pkg::FSF_IDLE: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge scl_clk or posedge reset) begin
      if (reset) begin
         shift_q <= fsf_pkg::RST_BYTE;
      end else if (start_pend) begin
         shift_q <= {7'h00, sda_i};
      end else if (run && !slot) begin
         shift_q <= {shift_q[6:0], sda_i};
      end
   end

   // Received byte stays put for a whole byte time, long enough to cross
   always_ff @(posedge scl_clk or posedge reset) begin
      if (reset) begin
         idx_q <= fsf_pkg::IDX_ADDR_HI;
         link_rx_q <= '0;
         rx_tog_q <= 1'b0;
      end else if (run && slot && state_q == fsf_pkg::FSF_ADDR) begin
         idx_q <= fsf_pkg::IDX_ADDR_HI;
      end else if (run && state_q == fsf_pkg::FSF_WRX && bit_q == fsf_pkg::BIT_LAST) begin
         link_rx_q <= '{idx: idx_q, data: {shift_q[6:0], sda_i}};
         rx_tog_q <= ~rx_tog_q;
         // Two address bytes span the whole array, then data
         if (idx_q != fsf_pkg::IDX_DATA) begin
            idx_q <= idx_q + 2'h1;
         end
      end
   end

   // Prefetched byte is taken at the acknowledge that opens each read byte
   always_ff @(posedge scl_clk or posedge reset) begin
      if (reset) begin
         tx_q <= fsf_pkg::RST_BYTE;
         take_tog_q <= 1'b0;
      end else if (run && slot && ((state_q == fsf_pkg::FSF_ADDR && match_w &&
                   shift_q[0] == fsf_pkg::RW_READ) ||
                   (state_q == fsf_pkg::FSF_RDX && !sda_i))) begin
         tx_q <= tx_hold_q;
         take_tog_q <= ~take_tog_q;
      end
   end

   // ************************************************
   // Link side, falling edge: line drive
   // ************************************************
   always_ff @(negedge scl_clk or posedge reset) begin
      if (reset) begin
         drive_q <= 1'b0;
      end else if (!run) begin
         drive_q <= 1'b0;
      end else if (state_q == fsf_pkg::FSF_RDX) begin
         // Release in the ninth clock for the master's answer
         drive_q <= !slot && !tx_q[tx_idx];
      end else begin
         drive_q <= slot && (state_q == fsf_pkg::FSF_WRX || match_w);
      end
   end

   // Never driven high: a zero with an enable
   assign sda_o = 1'b0;
   assign sda_oe = drive_q;

   // ************************************************
   // System side
   // ************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         wp_s1_q <= 1'b0;
         wp_s2_q <= 1'b0;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
         rx_s_q <= 3'h0;
         take_s_q <= 3'h0;
      end else begin
         wp_s1_q <= wp_i;
         wp_s2_q <= wp_s1_q;
         busy_s1_q <= (state_q != fsf_pkg::FSF_IDLE);
         busy_s2_q <= busy_s1_q;
         rx_s_q <= {rx_s_q[1:0], rx_tog_q};
         take_s_q <= {take_s_q[1:0], take_tog_q};
      end
   end

   assign rx_edge = rx_s_q[2] ^ rx_s_q[1];
   assign take_edge = take_s_q[2] ^ take_s_q[1];

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_valid_q <= 1'b0;
         mem_wr_q <= 1'b0;
         rx_word_q <= '0;
      end else begin
         rx_valid_q <= rx_edge;
         mem_wr_q <= rx_edge && link_rx_q.idx == fsf_pkg::IDX_DATA && !wp_s2_q;
         if (rx_edge) begin
            rx_word_q <= link_rx_q;
         end
      end
   end

   // Reset primes the hold register so the first read has data
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_take_q <= 1'b0;
         load_q <= 1'b1;
         tx_hold_q <= fsf_pkg::RST_BYTE;
      end else begin
         rd_take_q <= take_edge;
         load_q <= rd_take_q;
         if (load_q) begin
            tx_hold_q <= rd_byte;
         end
      end
   end

   assign rx_valid = rx_valid_q;
   assign rx_word = rx_word_q;
   assign mem_wr = mem_wr_q;
   assign rd_take = rd_take_q;
   assign link_busy = busy_s2_q;

   // ************************************************
   // Checks
   // ************************************************
   addr_ack_a: assert property (@(posedge scl_clk) disable iff (reset)
      run && slot && state_q == fsf_pkg::FSF_ADDR |-> drive_q == match_w)
      else $error("Address acknowledge does not follow match");

   mismatch_idle_a: assert property (@(posedge scl_clk) disable iff (reset)
      run && slot && state_q == fsf_pkg::FSF_ADDR && !match_w
      |=> state_q == fsf_pkg::FSF_IDLE || start_seen_q != $past(start_seen_q))
      else $error("Mismatched address did not return to standby");

   stop_standby_a: assert property (@(posedge scl_clk) disable iff (reset)
      stop_pend && !start_pend |=> state_q == fsf_pkg::FSF_IDLE)
      else $error("Stop did not return to standby");

   rise_capture_a: assert property (@(posedge scl_clk) disable iff (reset)
      run && !slot |=> shift_q[0] == $past(sda_i))
      else $error("Bit not captured on rising clock");

   tx_bit_a: assert property (@(posedge scl_clk) disable iff (reset)
      run && !slot && state_q == fsf_pkg::FSF_RDX |-> drive_q == !tx_q[tx_idx])
      else $error("Read bit on line is wrong");

   tx_release_a: assert property (@(posedge scl_clk) disable iff (reset)
      run && slot && state_q == fsf_pkg::FSF_RDX |-> !drive_q)
      else $error("Line held during master acknowledge");

   nack_release_a: assert property (@(posedge scl_clk) disable iff (reset)
      run && slot && state_q == fsf_pkg::FSF_RDX && sda_i
      |=> state_q == fsf_pkg::FSF_IDLE || start_seen_q != $past(start_seen_q) ##1 !drive_q)
      else $error("Bus not released after not-acknowledge");

   idle_quiet_a: assert property (@(posedge scl_clk) disable iff (reset)
      state_q == fsf_pkg::FSF_IDLE && $past(state_q) == fsf_pkg::FSF_IDLE |-> !drive_q)
      else $error("Line driven in standby");

   wp_block_a: assert property (@(posedge clk) disable iff (reset)
      wp_s2_q |=> !mem_wr)
      else $error("Array write while protected");

   wr_pass_a: assert property (@(posedge clk) disable iff (reset)
      rx_edge && !wp_s2_q && link_rx_q.idx == fsf_pkg::IDX_DATA
      |=> mem_wr && rx_valid && rx_word.idx == fsf_pkg::IDX_DATA)
      else $error("Unprotected data byte not written");

   load_after_take_a: assert property (@(posedge clk) disable iff (reset)
      rd_take |=> ##1 tx_hold_q == $past(rd_byte))
      else $error("Read byte not loaded after take");

   wr_cov_c: cover property (@(posedge clk) disable iff (reset) mem_wr);
   rd_cov_c: cover property (@(posedge clk) disable iff (reset) rd_take);
   miss_cov_c: cover property (@(posedge scl_clk) disable iff (reset)
      run && slot && state_q == fsf_pkg::FSF_ADDR && !match_w);
   nack_cov_c: cover property (@(posedge scl_clk) disable iff (reset)
      run && slot && state_q == fsf_pkg::FSF_RDX && sda_i);

endmodule

// >>> test/fsf_master_model.sv
// Behavioural bus master that drives the serial clock and data line.
// Assumes the bench resolves the open-drain data line with a pull-up.
module fsf_master_model (
   // Serial link
   output logic scl_clk,
   output logic sda_low,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 100ps;

   // ************************************************
   // Idle bus
   // ************************************************
   // Clock stands high between frames; only this side makes it
   initial begin
      scl_clk = 1'b1;
      sda_low = 1'b0;
   end

   // ************************************************
   // Bus conditions and bits
   // ************************************************
   // Works from idle and as a repeated start with the clock low
   task automatic start_cond();
      #40 sda_low = 1'b0;
      #40 scl_clk = 1'b1;
      #40 sda_low = 1'b1;
      #40 scl_clk = 1'b0;
   endtask

   task automatic stop_cond();
      #40 sda_low = 1'b1;
      #40 scl_clk = 1'b1;
      #40 sda_low = 1'b0;
      #40;
   endtask

   task automatic bit_xfer(input logic b, output logic r);
      #40 sda_low = ~b;
      #40 scl_clk = 1'b1;
      #40 r = sda_line;
      #40 scl_clk = 1'b0;
   endtask

   // A one in d or ack_in releases the line to the pull-up
   task automatic byte_xfer(input logic [7:0] d, input logic ack_in,
                            output logic [7:0] q, output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], q[i]);
      end
      bit_xfer(ack_in, ack_out);
   endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench for the two-wire slave front end.
// Assumes the master model as the only party besides the design on the link.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [3:0] TYPE_CODE = 4'h5; // Arbitrary type code
   logic clk, reset, scl_clk, m_low, sda_line, sda_oe, sda_o, wp_i;
   logic addr_sel_bit0, addr_sel_bit1, addr_sel_bit2;
   logic rx_valid, mem_wr, rd_take, link_busy, take_d;
   logic [7:0] rd_byte, hold_exp, q, e1, e2;
   logic [2:0] s, c;
   logic w, a;
   logic [7:0] d;
   fsf_pkg::fsf_rx_t rx_word;
   fsf_pkg::fsf_rx_t rx_q [$];
   logic [14:0] rows [6];
   int err_total = 0;
   int samples_checked = 0;
   int wr_cnt = 0;
   int take_cnt = 0;

   // Pull-up with wire-AND of both pull-downs
   assign sda_line = ~m_low & (~sda_oe | sda_o);

   fsf_frontend #(.DEV_TYPE(TYPE_CODE)) DUT (.clk(clk), .reset(reset), .scl_clk(scl_clk),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_sel_bit0(addr_sel_bit0),
      .addr_sel_bit1(addr_sel_bit1), .addr_sel_bit2(addr_sel_bit2), .wp_i(wp_i),
      .rx_valid(rx_valid), .rx_word(rx_word), .mem_wr(mem_wr), .rd_byte(rd_byte),
      .rd_take(rd_take), .link_busy(link_busy));
   fsf_master_model master (.scl_clk(scl_clk), .sda_low(m_low), .sda_line(sda_line));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // ************************************************
   // User-side monitor and read-data source
   // ************************************************
   // Hold register reloads one cycle after the consumed pulse
   always @(posedge clk) begin
      take_d <= rd_take;
      if (take_d === 1'b1) hold_exp <= rd_byte;
      if (rd_take === 1'b1) rd_byte <= rd_byte + 8'h1b;
      if (rd_take === 1'b1) take_cnt++;
      if (rx_valid === 1'b1) rx_q.push_back(rx_word);
      if (mem_wr === 1'b1) begin
         wr_cnt++;
         check(10'(rx_valid), 10'h1);
         check(10'(rx_word.idx), 10'(fsf_pkg::IDX_DATA));
      end
      if (sda_oe === 1'b1) check(10'(sda_o), 10'h0);
   end

   // Line may only move while the clock is low
   always @(sda_oe) if (scl_clk === 1'b1 && reset === 1'b0) check(10'h1, 10'h0);

   initial begin
      #1000000;
      err_total++;
      finish_test();
   end

   // ************************************************
   // Frame helpers
   // ************************************************
   task automatic frame_write(input logic [2:0] code, input logic [7:0] dv, input logic nack,
                              input int nb);
      logic [7:0] b [3];
      logic [7:0] qq;
      logic aa;
      b = '{8'h1c, 8'he2, dv};
      master.start_cond();
      master.byte_xfer({TYPE_CODE, code, 1'b0}, 1'b1, qq, aa);
      check(10'(aa), 10'(nack));
      for (int k = 0; k < nb && !nack; k++) begin
         master.byte_xfer(b[k], 1'b1, qq, aa);
         check(10'(aa), 10'h0);
      end
   endtask

   task automatic expect_rx(input int n, input logic [7:0] dv, input int wr_exp);
      logic [7:0] e [3];
      fsf_pkg::fsf_rx_t wd;
      e = '{8'h1c, 8'he2, dv};
      repeat (10) @(posedge clk);
      check(10'(rx_q.size()), 10'(n));
      for (int k = 0; k < n; k++) begin
         wd = rx_q.pop_front();
         check(wd, {2'(k), e[k]});
      end
      check(10'(wr_cnt), 10'(wr_exp));
      rx_q.delete();
      wr_cnt = 0;
   endtask

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      reset = 1'b1;
      {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0} = 3'h0;
      wp_i = 1'b0;
      rd_byte = 8'h5a;
      hold_exp = 8'h5a;
      take_d = 1'b0;
      // Straps, protect, mismatch and a reversed code
      rows = '{{3'h5, 1'b0, 3'h5, 8'ha3}, {3'h5, 1'b1, 3'h5, 8'h5c}, {3'h0, 1'b0, 3'h0, 8'h01},
               {3'h7, 1'b0, 3'h3, 8'hff}, {3'h6, 1'b0, 3'h6, 8'h80}, {3'h6, 1'b0, 3'h3, 8'h7f}};
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      @(posedge clk);
      #1 check({5'h0, sda_oe, rx_valid, mem_wr, rd_take, link_busy}, 10'h0);
      check(rx_word, 10'h0);
      $display("reset test done");
      repeat (3) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         {s, w, c, d} = rows[i];
         @(posedge clk);
         #1 {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0} = s;
         wp_i = w;
         frame_write(c, d, s != c, 3);
         master.stop_cond();
         expect_rx((s == c) ? 3 : 0, d, (s == c && !w) ? 1 : 0);
         if (s != c) check(10'(link_busy), 10'h0);
         $display("row %0d done", i);
      end
      // Address set, repeated start, read two bytes with protect high
      @(posedge clk);
      #1 {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0} = 3'h5;
      wp_i = 1'b1;
      frame_write(3'h5, 8'h00, 1'b0, 2);
      e1 = hold_exp;
      master.start_cond();
      master.byte_xfer({TYPE_CODE, 3'h5, fsf_pkg::RW_READ}, 1'b1, q, a);
      check(10'(a), 10'h0);
      check(10'(link_busy), 10'h1);
      master.byte_xfer(8'hff, 1'b0, q, a);
      check(10'(q), 10'(e1));
      e2 = hold_exp;
      master.byte_xfer(8'hff, 1'b1, q, a);
      check(10'(q), 10'(e2));
      check(10'(a), 10'h1);
      #1 check(10'(sda_oe), 10'h0);
      master.stop_cond();
      expect_rx(2, 8'h00, 0);
      check(10'(e2 != e1), 10'h1);
      check(10'(take_cnt), 10'h2);
      check(10'(link_busy), 10'h0);
      $display("read test done");
      // Stop in mid-byte, then a new frame at once
      @(posedge clk);
      #1 wp_i = 1'b0;
      frame_write(3'h5, 8'h00, 1'b0, 0);
      for (int k = 0; k < 4; k++) master.bit_xfer(1'b1, a);
      master.stop_cond();
      frame_write(3'h5, 8'h96, 1'b0, 3);
      master.stop_cond();
      expect_rx(3, 8'h96, 1);
      $display("abort test done");
      // Wrong type code
      master.start_cond();
      master.byte_xfer({4'h3, 3'h5, 1'b0}, 1'b1, q, a);
      check(10'(a), 10'h1);
      master.stop_cond();
      expect_rx(0, 8'h00, 0);
      check(10'(link_busy), 10'h0);
      $display("type test done");
      // Reset with the bus idle but a write frame left open
      frame_write(3'h5, 8'h00, 1'b0, 0);
      for (int k = 0; k < 2; k++) master.bit_xfer(1'b0, a);
      master.stop_cond();
      @(posedge clk);
      #1 reset = 1'b1;
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      @(posedge clk);
      #1 check({6'h0, sda_oe, rx_valid, mem_wr, link_busy}, 10'h0);
      repeat (2) @(posedge clk);
      frame_write(3'h5, 8'h4d, 1'b0, 3);
      master.stop_cond();
      expect_rx(3, 8'h4d, 1);
      $display("reset in frame test done");
      finish_test();
   end
endmodule
